// ---- common/charger_option_pkg.sv ----
// Constants and carrier types for the charger option register block.
// Assumes a single core clock domain and a serial register port on the device pins.
package charger_option_pkg;

    localparam logic [7:0] opt_offset = 8'h00;
    localparam logic [7:0] opt_reset = 8'h0e;

    localparam int bit_reserved = 7;
    localparam int bit_short_hiccup_disable = 6;
    localparam int bit_learn = 5;
    localparam int bit_input_monitor_gain_sel = 4;
    localparam int bit_battery_monitor_gain_sel = 3;
    localparam int bit_battery_switch_linear_enable = 2;
    localparam int bit_input_limit_loop_enable = 1;
    localparam int bit_charge_disable = 0;

    localparam int gain_w = 6;
    localparam logic [5:0] input_gain_low = 6'h14;
    localparam logic [5:0] input_gain_high = 6'h28;
    localparam logic [5:0] battery_gain_low = 6'h08;
    localparam logic [5:0] battery_gain_high = 6'h10;

    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam logic [6:0] default_dev_addr = 7'h2a;

    typedef struct packed {
        logic short_hiccup_trigger;
        logic battery_switch_full_on;
        logic switching_halt;
        logic learn_mode;
        logic precharge_clamp_enable;
        logic input_limit_loop_enable;
        logic charge_disable;
        logic [5:0] input_monitor_gain;
        logic [5:0] battery_monitor_gain;
    } charger_ctrl_t;

    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

endpackage

// ---- rtl/charger_option_bank.sv ----
// Option register and the control levels it drives.
// Assumes writes arrive as one-cycle strobes from the serial port logic.
`timescale 1ns/1ps
module charger_option_bank
(
    input wire logic core_clk,
    input wire logic rst,
    input wire charger_option_pkg::reg_write_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic sys_below_min,
    output charger_option_pkg::charger_ctrl_t ctrl,
    output logic [7:0] option_value
);

    function automatic logic opt_hit(input logic [7:0] a);
        return a == charger_option_pkg::opt_offset;
    endfunction

    logic [7:0] opt;
    logic [7:0] next_opt;
    charger_option_pkg::charger_ctrl_t next_ctrl;

    always_comb
    begin
        next_opt = opt;
        if (wr.stb && opt_hit(wr.addr))
        begin
            next_opt = wr.data;
        end
        next_ctrl.short_hiccup_trigger = sys_below_min
            && !opt[charger_option_pkg::bit_short_hiccup_disable];
        next_ctrl.learn_mode = opt[charger_option_pkg::bit_learn];
        next_ctrl.switching_halt = opt[charger_option_pkg::bit_learn];
        next_ctrl.battery_switch_full_on = opt[charger_option_pkg::bit_learn]
            || !opt[charger_option_pkg::bit_battery_switch_linear_enable];
        next_ctrl.precharge_clamp_enable =
            opt[charger_option_pkg::bit_battery_switch_linear_enable];
        next_ctrl.input_limit_loop_enable =
            opt[charger_option_pkg::bit_input_limit_loop_enable];
        next_ctrl.charge_disable = opt[charger_option_pkg::bit_charge_disable];
        next_ctrl.input_monitor_gain = opt[charger_option_pkg::bit_input_monitor_gain_sel]
            ? charger_option_pkg::input_gain_high : charger_option_pkg::input_gain_low;
        next_ctrl.battery_monitor_gain = opt[charger_option_pkg::bit_battery_monitor_gain_sel]
            ? charger_option_pkg::battery_gain_high
            : charger_option_pkg::battery_gain_low;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            opt <= charger_option_pkg::opt_reset;
            ctrl <= '0;
            option_value <= charger_option_pkg::opt_reset;
        end
        else
        begin
            opt <= next_opt;
            ctrl <= next_ctrl;
            option_value <= next_opt;
        end
    end

    // Whole byte read back, reserved bit included; unmapped offsets read zero
    assign rd_data = opt_hit(rd_addr) ? opt : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    property p_reset_value;
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> opt == charger_option_pkg::opt_reset;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    property p_write_all;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) |=> opt == $past(wr.data) && option_value == opt;
    endproperty
    a_write_all: assert property (p_write_all) else $error("write not stored");

    property p_miss_keeps;
        @(posedge core_clk) disable iff (rst)
        wr.stb && !opt_hit(wr.addr) |=> $stable(opt);
    endproperty
    a_miss_keeps: assert property (p_miss_keeps) else $error("unmapped write changed reg");

    property p_hiccup_off;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) && wr.data[charger_option_pkg::bit_short_hiccup_disable]
        |-> ##2 !ctrl.short_hiccup_trigger;
    endproperty
    a_hiccup_off: assert property (p_hiccup_off) else $error("hiccup not disabled");

    property p_learn;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) && wr.data[charger_option_pkg::bit_learn]
        |-> ##2 ctrl.switching_halt && ctrl.battery_switch_full_on;
    endproperty
    a_learn: assert property (p_learn) else $error("learn mode not entered");

    property p_input_gain;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) |-> ##2 ctrl.input_monitor_gain
            == ($past(wr.data[charger_option_pkg::bit_input_monitor_gain_sel], 2)
            ? charger_option_pkg::input_gain_high : charger_option_pkg::input_gain_low);
    endproperty
    a_input_gain: assert property (p_input_gain) else $error("input gain wrong");

    property p_battery_gain;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) |-> ##2 ctrl.battery_monitor_gain
            == ($past(wr.data[charger_option_pkg::bit_battery_monitor_gain_sel], 2)
            ? charger_option_pkg::battery_gain_high : charger_option_pkg::battery_gain_low);
    endproperty
    a_battery_gain: assert property (p_battery_gain) else $error("battery gain wrong");

    property p_linear_off;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr) && !wr.data[charger_option_pkg::bit_battery_switch_linear_enable]
        |-> ##2 ctrl.battery_switch_full_on && !ctrl.precharge_clamp_enable;
    endproperty
    a_linear_off: assert property (p_linear_off) else $error("switch not fully on");

    property p_loop;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr)
        |-> ##2 ctrl.input_limit_loop_enable
            == $past(wr.data[charger_option_pkg::bit_input_limit_loop_enable], 2);
    endproperty
    a_loop: assert property (p_loop) else $error("input loop enable wrong");

    property p_inhibit;
        @(posedge core_clk) disable iff (rst)
        wr.stb && opt_hit(wr.addr)
        |-> ##2 ctrl.charge_disable
            == $past(wr.data[charger_option_pkg::bit_charge_disable], 2);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charge inhibit wrong");

endmodule

// ---- rtl/charger_option_ctrl.sv ----
// Serial register port slave and the charger option register.
// Assumes scl and sda_in are already synchronous to core_clk; no clock stretching.
//
// Functional notes
// - Bit 6 set stops hiccup protection even with system rail below 2.4 V.
// - Bit 5 set enters learn mode: battery switch on, switching halted.
// - Bit 4 picks input monitor gain, 20x when clear, 40x when set.
// - Bit 3 picks battery monitor gain, 8x when clear, 16x when set.
// - Bit 2 clear keeps battery switch fully on, no 384mA precharge clamp.
// - Bit 1 clear disables the input current regulation loop.
// - Bit 0 set inhibits charging until cleared.
// - Register sits at offset 0x00 and resets to 0x0E.
`timescale 1ns/1ps
module charger_option_ctrl
#(
    parameter logic [6:0] dev_addr = charger_option_pkg::default_dev_addr
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sys_below_min,
    output charger_option_pkg::charger_ctrl_t ctrl,
    output logic [7:0] option_value
);

    typedef enum logic [6:0]
    {
        st_idle = 7'h01,
        st_addr = 7'h02,
        st_ptr = 7'h04,
        st_wdata = 7'h08,
        st_ack = 7'h10,
        st_rdata = 7'h20,
        st_rack = 7'h40
    } port_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Pin edge detection
    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            scl_d <= 1'b1;
            sda_q <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            scl_d <= scl_q;
            sda_q <= sda_in;
            sda_d <= sda_q;
        end
    end

    assign scl_rise = scl_q && !scl_d;
    assign scl_fall = !scl_q && scl_d;
    assign start_seen = scl_q && scl_d && sda_d && !sda_q;
    assign stop_seen = scl_q && scl_d && !sda_d && sda_q;

    ////////////////////////////////////////////////////////////////////////////
    // Byte-level port state
    port_state_t state;
    port_state_t next_state;
    port_state_t follow;
    port_state_t next_follow;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic next_sda_oe;
    charger_option_pkg::reg_write_t wr;
    charger_option_pkg::reg_write_t next_wr;
    logic [7:0] rd_data;

    always_comb
    begin
        next_state = state;
        next_follow = follow;
        next_cnt = cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_sda_oe = sda_oe;
        next_wr = wr;
        next_wr.stb = 1'b0;
        if (stop_seen)
        begin
            next_state = st_idle;
            next_sda_oe = 1'b0;
        end
        else if (start_seen)
        begin
            next_state = st_addr;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end
        else
        begin
            unique case (state)
                st_idle:
                begin
                    next_sda_oe = 1'b0;
                end
                st_addr, st_ptr, st_wdata:
                begin
                    if (scl_rise)
                    begin
                        next_shift = {shift[6:0], sda_q};
                        next_cnt = cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == charger_option_pkg::bits_per_byte)
                    begin
                        next_sda_oe = 1'b1;
                        next_state = st_ack;
                        next_follow = st_wdata;
                        if (state == st_addr)
                        begin
                            next_follow = shift[0] ? st_rdata : st_ptr;
                            if (shift[7:1] != dev_addr)
                            begin
                                next_sda_oe = 1'b0;
                                next_state = st_idle;
                            end
                        end
                        else if (state == st_ptr)
                        begin
                            next_ptr = shift;
                        end
                        else
                        begin
                            // Whole byte lands at once, reserved bit as sent
                            next_wr.stb = 1'b1;
                            next_wr.addr = ptr;
                            next_wr.data = shift;
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                st_ack, st_rack:
                begin
                    if (state == st_rack && scl_rise && sda_q)
                    begin
                        next_state = st_idle;
                    end
                    else if (scl_fall)
                    begin
                        next_cnt = 4'h0;
                        next_state = (state == st_rack) ? st_rdata : follow;
                        next_sda_oe = 1'b0;
                        if (state == st_rack || follow == st_rdata)
                        begin
                            next_shift = rd_data;
                            next_sda_oe = !rd_data[7];
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                st_rdata:
                begin
                    if (scl_rise)
                    begin
                        next_cnt = cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt == charger_option_pkg::bits_per_byte)
                        begin
                            next_sda_oe = 1'b0;
                            next_state = st_rack;
                        end
                        else
                        begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_oe = !shift[6];
                        end
                    end
                end
                default:
                begin
                    next_state = st_idle;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= st_idle;
            follow <= st_idle;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr <= '0;
        end
        else
        begin
            state <= next_state;
            follow <= next_follow;
            cnt <= next_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            wr <= next_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register and control levels
    charger_option_bank u_bank
    (
        .core_clk(core_clk),
        .rst(rst),
        .wr(wr),
        .rd_addr(ptr),
        .rd_data(rd_data),
        .sys_below_min(sys_below_min),
        .ctrl(ctrl),
        .option_value(option_value)
    );

    property p_write_acked;
        @(posedge core_clk) disable iff (rst)
        wr.stb |-> sda_oe && state == st_ack && ptr == wr.addr + 8'h01;
    endproperty
    a_write_acked: assert property (p_write_acked) else $error("write without ack");

    property p_stop_releases;
        @(posedge core_clk) disable iff (rst)
        stop_seen |=> !sda_oe && state == st_idle;
    endproperty
    a_stop_releases: assert property (p_stop_releases) else $error("stop not honoured");

endmodule

// ---- sim/i2c_host_model.sv ----
// Behavioural serial host that reaches the option register over the two-wire port.
// Assumes the bench calls its tasks right after a rising edge of core_clk.
`timescale 1ns/1ps
module i2c_host_model
(
    input wire logic core_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_in
);
    logic m_low = 1'b0;
    initial scl = 1'b1;

    // Open-drain data wire with pull-up
    assign sda_in = ~(m_low | sda_oe);

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Data moves only while the clock is low
    task automatic bit_cyc(input logic b, output logic s);
        tick(1);
        m_low <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(3);
        s = sda_in;
        tick(3);
        scl <= 1'b0;
    endtask

    task automatic start();
        tick(1);
        m_low <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(6);
        m_low <= 1'b1;
        tick(6);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(1);
        m_low <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(6);
        m_low <= 1'b0;
        tick(6);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(b[i], s);
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask

    // Released acknowledge slot ends a read
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(1'b1, s);
            b[i] = s;
        end
        bit_cyc(last, s);
    endtask
endmodule

// ---- sim/charger_option_control_reg_tb_top.sv ----
// Self-checking bench for the charger option register behind the serial port.
// Assumes the host model in i2c_host_model.sv and the design package.
`timescale 1ns/1ps
module charger_option_control_reg_tb_top;
    localparam logic [6:0] dev = charger_option_pkg::default_dev_addr;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sys_below_min = 1'b0;
    logic scl;
    logic sda_in;
    logic sda_oe;
    logic sda_out;
    charger_option_pkg::charger_ctrl_t ctrl;
    logic [7:0] option_value;
    logic [7:0] m_reg = 8'h0e;
    logic [31:0] seed = 32'hb5a7;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    charger_option_ctrl DUT
    (
        .core_clk(core_clk),
        .rst(rst),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .sys_below_min(sys_below_min),
        .ctrl(ctrl),
        .option_value(option_value)
    );

    i2c_host_model host
    (
        .core_clk(core_clk),
        .sda_oe(sda_oe),
        .scl(scl),
        .sda_in(sda_in)
    );

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            $display("[ERR] %0t run took too long", $time);
            test_done();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic charger_option_pkg::charger_ctrl_t exp_ctrl(input logic [7:0] v);
        charger_option_pkg::charger_ctrl_t c;
        c.short_hiccup_trigger = sys_below_min & ~v[6];
        c.battery_switch_full_on = v[5] | ~v[2];
        c.switching_halt = v[5];
        c.learn_mode = v[5];
        c.precharge_clamp_enable = v[2];
        c.input_limit_loop_enable = v[1];
        c.charge_disable = v[0];
        c.input_monitor_gain = v[4] ? 6'h28 : 6'h14;
        c.battery_monitor_gain = v[3] ? 6'h10 : 6'h08;
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [6:0] a, input logic [7:0] p,
                             input logic [7:0] d[$], output logic all);
        logic k;
        host.start();
        host.send_byte({a, 1'b0}, k);
        all = k;
        host.send_byte(p, k);
        all = all & k;
        foreach (d[i])
        begin
            host.send_byte(d[i], k);
            all = all & k;
        end
        host.stop();
    endtask

    task automatic check_all(input logic [7:0] p);
        logic k;
        logic [7:0] r;
        logic [7:0] r_next;
        host.start();
        host.send_byte({dev, 1'b0}, k);
        host.send_byte(p, k);
        host.start();
        host.send_byte({dev, 1'b1}, k);
        host.recv_byte(1'b0, r);
        host.recv_byte(1'b1, r_next);
        host.stop();
        chk(32'(r), 32'(p == 8'h00 ? m_reg : 8'h00), "read back");
        chk(32'(r_next), 32'h0, "next offset read");
        chk(32'(sda_out), 32'h0, "data drive level");
        chk(32'(option_value), 32'(m_reg), "stored byte");
        chk(32'(ctrl), 32'(exp_ctrl(m_reg)), "controls");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic ok;
        logic [7:0] pat[$] = '{8'h7f, 8'h00, 8'h40, 8'h3b};
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check_all(8'h00);
        $display("test reset value done");

        for (int i = 0; i < 14; i++)
        begin
            m_reg = i < 4 ? pat[i] : 8'(xs()) & 8'h7f;
            sys_below_min <= i < 4 ? 1'b1 : 1'(xs());
            reg_write(dev, 8'h00, '{m_reg}, ok);
            chk(32'(ok), 32'h1, "write acknowledge");
            check_all(8'h00);
        end
        $display("test bit fields done");

        m_reg = 8'h0a;
        reg_write(dev, 8'h00, '{m_reg, 8'h40}, ok);
        chk(32'(ok), 32'h1, "burst acknowledge");
        check_all(8'h00);
        $display("test burst done");

        reg_write(dev, 8'h05, '{8'h55}, ok);
        chk(32'(ok), 32'h1, "unmapped acknowledge");
        check_all(8'h05);
        reg_write(7'h2b, 8'h00, '{8'h11}, ok);
        chk(32'(ok), 32'h0, "foreign address");
        check_all(8'h00);
        $display("test refusals done");

        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(32'(option_value), 32'h0e, "value in reset");
        rst <= 1'b0;
        m_reg = 8'h0e;
        repeat (2) @(posedge core_clk);
        check_all(8'h00);
        $display("test second reset done");
        test_done();
    end
endmodule
